// [include/ext_bus_pkg.sv]
// constants, register map and state codes for the external basic bus interface
// assumes a 24-bit internal address, 32-bit apb data and a 16-bit external data bus
package ext_bus_pkg;

  // register indices; apb byte address is four times the index
  localparam logic [23:0] IDX_STATUS     = 24'hfee018; // bus mode and activity, read only
  localparam logic [23:0] IDX_SEL_DIR    = 24'hfee019; // direction bits for selects 0 to 3
  localparam logic [23:0] IDX_WIDTH      = 24'hfee01a; // area_width_select_reg
  localparam logic [23:0] IDX_STATES     = 24'hfee01b; // access_state_select_reg
  localparam logic [23:0] IDX_WAIT_UP    = 24'hfee01c; // wait_count_upper_reg, areas 7 to 4
  localparam logic [23:0] IDX_WAIT_LO    = 24'hfee01d; // wait_count_lower_reg, areas 3 to 0
  localparam logic [23:0] IDX_ADR_CTRL   = 24'hfee01e; // address_update_control
  localparam logic [23:0] IDX_SEL_EN     = 24'hfee01f; // select_output_enable_reg

  // reset values
  localparam logic [7:0]  RST_WIDTH      = 8'hff;      // all areas 8-bit
  localparam logic [7:0]  RST_STATES     = 8'hff;      // all areas three-state
  localparam logic [7:0]  RST_WAIT       = 8'hff;      // three program waits everywhere
  localparam logic [3:0]  RST_SEL_EN     = 4'h0;       // selects 4 to 7 are inputs
  localparam logic        RST_ADR_MODE   = 1'b1;       // update mode 1
  localparam logic [3:0]  SEL_EN_FILL    = 4'hf;       // low nibble of select enable reads ones
  localparam logic [6:0]  ADR_CTRL_FILL  = 7'h7f;      // upper bits of address control read ones

  // field positions
  localparam int          ADR_MODE_BIT   = 0;          // address_update_mode_bit
  localparam int          SEL_EN_LSB     = 4;          // select_output_enable_bit 4 at bit 4
  localparam int          AREA_LSB       = 21;         // area number in address bits 23:21

  // strap settling: edges after reset release before straps are taken
  localparam logic [1:0]  STRAP_WAIT     = 2'h2;

  // access sizes from internal masters
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } size_t;

  // bus cycle states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_T1   = 5'h02,
    ST_T2   = 5'h04,
    ST_TW   = 5'h08,
    ST_T3   = 5'h10
  } bus_state_t;

endpackage : ext_bus_pkg

// [design/ext_bus_if.sv]
// external basic bus interface: area settings, area selects, address update
// modes, lane alignment and strobes, with an apb register slave
// assumes internal masters hold a request until req_ready_o, that straps are
// asynchronous, and that data pins answer within the bus clock's own cycle
//
// Behaviour
// - width bit: clear is 16-bit, set is 8-bit
// - any 16-bit area gives 16-bit bus mode
// - state bit: clear two states, set three
// - two-state areas never take wait states
// - three-state areas take 0 to 3 program waits
// - internal accesses use fixed width and timing
// - one active-low select per area in expanded mode
// - selects 0-3 gated by direction bits; reset values
// - with rom enabled selects 0-3 reset as inputs
// - selects 4-7 enabled by select enable bits
// - selects stay high on internal accesses
// - selects decoded from outgoing address lines
// - update mode 1 updates address every cycle
// - update mode 2 updates address only externally
// - mode bit chooses mode; reset gives mode 1
// - address control register at index fee01e
// - split reads in mode 2 need no hold
// - 8-bit area: upper lane, one byte per cycle
// - 16-bit area: byte or word, long as two
// - 16-bit byte: even upper lane, odd lower
// - one read strobe serves both lanes
// - upper and lower write strobes per lane
// - unused write lane undetermined, read lane ignored
// - mode bit clear is mode 2, set mode 1
// - select enable bits reset clear, reads 0f
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`default_nettype none

module ext_bus_if
(
  input  wire logic              core_clk_i,          // system clock, 125 mhz
  input  wire logic              arst_n_i,            // asynchronous reset, active low
  // apb register port
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [25:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // straps from mode pins
  input  wire logic              expanded_mode_i,     // high in expanded modes
  input  wire logic              rom_enabled_i,       // high when on-chip rom is enabled
  // internal master request
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire logic [23:0]       req_addr_i,
  input  wire logic              req_write_i,
  input  wire ext_bus_pkg::size_t req_size_i,
  input  wire logic [31:0]       req_wdata_i,
  input  wire logic              req_internal_i,      // target is on-chip rom, ram or i/o
  output logic                   rsp_valid_o,
  output logic      [31:0]       rsp_rdata_o,
  // external bus
  output logic      [23:0]       ext_addr_o,
  input  wire logic [15:0]       ext_data_i,
  output logic      [15:0]       ext_data_o,
  output logic      [1:0]        ext_data_oe_o,       // bit 1 upper lane, bit 0 lower lane
  output logic                   read_strobe_n_o,
  output logic                   upper_write_strobe_n_o,
  output logic                   lower_write_strobe_n_o,
  output logic      [7:0]        area_select_n_o,
  output logic      [7:0]        area_select_oe_o,
  output logic                   bus16_mode_o         // high in 16-bit bus mode
);
  import ext_bus_pkg::*;

  // every flip-flop of the block
  typedef struct packed {
    bus_state_t  st;          // bus cycle state
    logic [23:0] addr;        // external address pins
    logic [23:0] base;        // address of the request
    logic [1:0]  beat;        // current bus cycle within the access
    logic [1:0]  beats_left;  // bus cycles still to run after this one
    logic        wr;          // access is a write
    logic        internal;    // access targets on-chip space
    logic        wide;        // area is 16-bit
    logic        three;       // area is three-state
    logic [1:0]  waits_left;  // program waits still to insert
    size_t       size;        // access size
    logic [31:0] wsh;         // write data, left aligned, shifted per cycle
    logic [31:0] rsh;         // read data, shifted in per cycle
    logic [15:0] dout;        // external data out
    logic [1:0]  doe;         // external data enables
    logic        rd_n;        // read strobe
    logic        hwr_n;       // upper write strobe
    logic        lwr_n;       // lower write strobe
    logic        cs_act;      // an external cycle is on the pins
    logic [7:0]  width;       // area_width_select_reg
    logic [7:0]  states;      // access_state_select_reg
    logic [7:0]  wait_up;     // wait_count_upper_reg
    logic [7:0]  wait_lo;     // wait_count_lower_reg
    logic [3:0]  sel_en;      // select_output_enable_reg bits 7:4
    logic [3:0]  sel_dir;     // direction bits of selects 0 to 3
    logic        adr_mode;    // address_update_mode_bit
    logic [31:0] prdata;      // apb read data
    logic        pready;      // apb ready
    logic        pslverr;     // apb error
    logic        rsp_valid;   // access done pulse
    logic [31:0] rsp_data;    // assembled read data
    logic [1:0]  strap_s1;    // strap synchroniser, first stage
    logic [1:0]  strap_s2;    // strap synchroniser, second stage
    logic [1:0]  strap_cnt;   // edges since reset release
    logic        strap_done;  // straps taken
    logic        expanded;    // captured expanded mode
  } state_t;

  state_t q;                  // registered state
  state_t d;                  // next state

  // one-hot decode of an area number
  function automatic logic [7:0] area_onehot(input logic [2:0] area);
    area_onehot = 8'h01 << area;
  endfunction : area_onehot

  // program wait count of an area
  function automatic logic [1:0] area_waits(input logic [2:0] area,
                                            input logic [7:0] up,
                                            input logic [7:0] lo);
    logic [15:0] all;
    all = {up, lo};
    area_waits = all[{area, 1'b0} +: 2];
  endfunction : area_waits

  // address of a bus cycle within an access
  function automatic logic [23:0] beat_addr(input logic [23:0] base,
                                            input logic [1:0]  beat,
                                            input logic        wide,
                                            input size_t       size);
    if (!wide) begin
      beat_addr = base + {22'h0, beat};
    end else if (size == SZ_BYTE) begin
      beat_addr = base;
    end else begin
      beat_addr = base + {21'h0, beat, 1'b0};
    end
  endfunction : beat_addr

  logic [23:0] pidx;          // apb register index
  logic [31:0] rd_val;        // register read value
  logic        rd_hit;        // index is mapped
  logic        apb_wr;        // write takes effect this edge
  logic [2:0]  req_area;      // area of the incoming request
  logic        up_lane;       // this cycle uses the upper lane
  logic        lo_lane;       // this cycle uses the lower lane
  logic        last_state;    // current state ends the bus cycle
  logic [23:0] next_addr;     // address of the next bus cycle
  logic [7:0]  sel_oe;        // select output enables

  assign pidx   = paddr_i[25:2];
  assign apb_wr = psel_i & penable_i & q.pready & pwrite_i;

  // register read mux
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0;
    case (pidx)
      IDX_STATUS:   rd_val = {30'h0, q.st != ST_IDLE, bus16_mode_o};
      IDX_SEL_DIR:  rd_val = {28'h0, q.sel_dir};
      IDX_WIDTH:    rd_val = {24'h0, q.width};
      IDX_STATES:   rd_val = {24'h0, q.states};
      IDX_WAIT_UP:  rd_val = {24'h0, q.wait_up};
      IDX_WAIT_LO:  rd_val = {24'h0, q.wait_lo};
      IDX_ADR_CTRL: rd_val = {24'h0, ADR_CTRL_FILL, q.adr_mode};
      IDX_SEL_EN:   rd_val = {24'h0, q.sel_en, SEL_EN_FILL};
      default:      rd_hit = 1'b0;                                     // unmapped reads zero
    endcase
  end

  // lane use of the cycle in flight
  assign up_lane    = !q.wide || (q.size != SZ_BYTE) || !q.addr[0];
  assign lo_lane    = q.wide && ((q.size != SZ_BYTE) || q.addr[0]);
  assign req_area   = req_addr_i[AREA_LSB +: 3];
  assign last_state = (q.st == ST_T3) || (q.st == ST_T2 && !q.three);
  assign next_addr  = beat_addr(q.base, q.beat + 2'h1, q.wide, q.size);

  // next state of the whole block
  always_comb begin
    d           = q;
    d.rsp_valid = 1'b0;
    // synchronisers: first stage read only by the second
    d.strap_s1  = {expanded_mode_i, rom_enabled_i};
    d.strap_s2  = q.strap_s1;

    // straps are taken once they have crossed the synchroniser
    if (!q.strap_done) begin
      if (q.strap_cnt == STRAP_WAIT) begin
        d.strap_done = 1'b1;
        d.expanded   = q.strap_s2[1];
        d.sel_dir    = {3'h0, ~q.strap_s2[0]};
      end else begin
        d.strap_cnt = q.strap_cnt + 2'h1;
      end
    end

    // apb: answer in the first access cycle, writes land at that edge
    d.pready  = psel_i & ~penable_i;
    d.pslverr = psel_i & ~penable_i & ~rd_hit;
    d.prdata  = (psel_i & ~penable_i & ~pwrite_i) ? rd_val : 32'h0;
    if (apb_wr) begin
      case (pidx)
        IDX_SEL_DIR:  d.sel_dir  = pwdata_i[3:0];
        IDX_WIDTH:    d.width    = pwdata_i[7:0];
        IDX_STATES:   d.states   = pwdata_i[7:0];
        IDX_WAIT_UP:  d.wait_up  = pwdata_i[7:0];
        IDX_WAIT_LO:  d.wait_lo  = pwdata_i[7:0];
        IDX_ADR_CTRL: d.adr_mode = pwdata_i[ADR_MODE_BIT];
        IDX_SEL_EN:   d.sel_en   = pwdata_i[SEL_EN_LSB +: 4];
        default:      d.adr_mode = q.adr_mode;                         // writes ignored
      endcase
    end

    case (q.st)
      // take a request and set up its first bus cycle
      ST_IDLE: begin
        if (req_valid_i && q.strap_done) begin
          d.st       = ST_T1;
          d.base     = req_addr_i;
          d.beat     = 2'h0;
          d.wr       = req_write_i;
          d.size     = req_size_i;
          d.internal = req_internal_i;
          d.rsh      = 32'h0;
          if (req_internal_i) begin
            // fixed two-state cycle, no strobes, no selects
            d.wide       = 1'b1;
            d.three      = 1'b0;
            d.waits_left = 2'h0;
            d.beats_left = 2'h0;
            d.cs_act     = 1'b0;
            if (q.adr_mode) begin
              d.addr = req_addr_i;
            end
          end else begin
            d.wide       = ~q.width[req_area];
            d.three      = q.states[req_area];
            d.waits_left = q.states[req_area] ?
                           area_waits(req_area, q.wait_up, q.wait_lo) : 2'h0;
            d.addr       = req_addr_i;
            d.cs_act     = 1'b1;
            if (q.width[req_area]) begin
              d.beats_left = (req_size_i == SZ_LONG) ? 2'h3 :
                             (req_size_i == SZ_WORD) ? 2'h1 : 2'h0;
            end else begin
              d.beats_left = (req_size_i == SZ_LONG) ? 2'h1 : 2'h0;
            end
            // left align write data so each cycle takes the top
            case (req_size_i)
              SZ_BYTE: d.wsh = {req_wdata_i[7:0], 24'h0};
              SZ_WORD: d.wsh = {req_wdata_i[15:0], 16'h0};
              default: d.wsh = req_wdata_i;
            endcase
          end
        end
      end
      // first state: address and select out; write data driven from the second state
      ST_T1: begin
        d.st = ST_T2;
        if (!q.internal) begin
          if (q.wr) begin
            d.dout = (!q.wide || q.size == SZ_BYTE) ?
                     {q.wsh[31:24], q.wsh[31:24]} : q.wsh[31:16];
            d.doe  = 2'b11;
            d.hwr_n = ~up_lane;
            d.lwr_n = ~lo_lane;
          end else begin
            d.doe  = 2'b00;
            d.rd_n = 1'b0;
          end
        end
      end
      // second state, then waits or the third state
      ST_T2: begin
        if (q.three) begin
          d.st = (q.waits_left != 2'h0) ? ST_TW : ST_T3;
        end
      end
      // program waits
      ST_TW: begin
        d.waits_left = q.waits_left - 2'h1;
        if (q.waits_left == 2'h1) begin
          d.st = ST_T3;
        end
      end
      ST_T3: begin
        d.st = ST_T3;
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // end of a bus cycle: capture read data, release strobes
    if (last_state) begin
      d.rd_n  = 1'b1;
      d.hwr_n = 1'b1;
      d.lwr_n = 1'b1;
      d.doe   = 2'b00;
      if (!q.internal && !q.wr) begin
        if (q.wide && q.size != SZ_BYTE) begin
          d.rsh = {q.rsh[15:0], ext_data_i};
        end else if (lo_lane) begin
          d.rsh = {q.rsh[23:0], ext_data_i[7:0]};
        end else begin
          d.rsh = {q.rsh[23:0], ext_data_i[15:8]};
        end
      end
      d.wsh = (q.wide && q.size != SZ_BYTE) ? {q.wsh[15:0], 16'h0} :
                                               {q.wsh[23:0], 8'h0};
      if (q.beats_left != 2'h0) begin
        // next bus cycle of a split access; no address hold promised
        d.st         = ST_T1;
        d.beat       = q.beat + 2'h1;
        d.beats_left = q.beats_left - 2'h1;
        d.addr       = next_addr;
        d.waits_left = area_waits(q.addr[AREA_LSB +: 3], q.wait_up, q.wait_lo);
        if (!q.three) begin
          d.waits_left = 2'h0;
        end
      end else begin
        d.st        = ST_IDLE;
        d.cs_act    = 1'b0;
        d.rsp_valid = 1'b1;
        d.rsp_data  = d.rsh;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q            <= '0;
      q.st         <= ST_IDLE;
      q.rd_n       <= 1'b1;
      q.hwr_n      <= 1'b1;
      q.lwr_n      <= 1'b1;
      q.width      <= RST_WIDTH;
      q.states     <= RST_STATES;
      q.wait_up    <= RST_WAIT;
      q.wait_lo    <= RST_WAIT;
      q.sel_en     <= RST_SEL_EN;
      q.adr_mode   <= RST_ADR_MODE;
    end else begin
      q <= d;
    end
  end

  // select enables: direction bits for 0 to 3, enable bits for 4 to 7
  assign sel_oe = q.expanded ? {q.sel_en, q.sel_dir} : 8'h00;

  // outputs
  assign prdata_o               = q.prdata;
  assign pready_o               = q.pready;
  assign pslverr_o              = q.pslverr;
  assign req_ready_o            = (q.st == ST_IDLE) && q.strap_done;
  assign rsp_valid_o            = q.rsp_valid;
  assign rsp_rdata_o            = q.rsp_data;
  assign ext_addr_o             = q.addr;
  assign ext_data_o             = q.dout;
  assign ext_data_oe_o          = q.doe;
  assign read_strobe_n_o        = q.rd_n;
  assign upper_write_strobe_n_o = q.hwr_n;
  assign lower_write_strobe_n_o = q.lwr_n;
  // selects decode the address on the pins, high on internal cycles
  assign area_select_n_o        = ~(area_onehot(q.addr[AREA_LSB +: 3]) &
                                    {8{q.cs_act}});
  assign area_select_oe_o       = sel_oe;
  assign bus16_mode_o           = (q.width != 8'hff);

endmodule : ext_bus_if

`default_nettype wire

// [test/ext_bus_if_sva.sv]
// checker for the external bus block: selects, strobes, lanes, apb
// assumes it is bound to ext_bus_if and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module ext_bus_if_sva
(
  input wire logic        core_clk_i,             // bus clock
  input wire logic        arst_n_i,               // reset, active low
  input wire logic        psel_i,                 // apb select
  input wire logic        penable_i,              // apb enable
  input wire logic        pready_o,               // apb ready
  input wire logic        pslverr_o,              // apb error
  input wire logic        req_valid_i,            // request present
  input wire logic        req_ready_o,            // request accepted
  input wire logic        req_internal_i,         // on-chip target
  input wire logic        rsp_valid_o,            // access done
  input wire logic [23:0] ext_addr_o,             // external address
  input wire logic [1:0]  ext_data_oe_o,          // lane drive enables
  input wire logic        read_strobe_n_o,        // read strobe
  input wire logic        upper_write_strobe_n_o, // upper write strobe
  input wire logic        lower_write_strobe_n_o, // lower write strobe
  input wire logic [7:0]  area_select_n_o         // area selects
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  apb_zero_wait_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("apb answer late");
  apb_err_ready_a: assert property (pslverr_o |-> pready_o && psel_i)
    else $error("error without ready");
  int_sel_high_a: assert property (req_valid_i && req_ready_o && req_internal_i |=>
    (area_select_n_o == 8'hff)[*2]) else $error("internal select low");
  one_select_a: assert property ($onehot0(~area_select_n_o))
    else $error("two selects low");
  sel_decode_a: assert property (area_select_n_o != 8'hff |->
    !area_select_n_o[ext_addr_o[23:21]]) else $error("select not from address");
  rd_lead_a: assert property ($fell(read_strobe_n_o) |->
    $past(area_select_n_o) != 8'hff) else $error("read strobe before select");
  rd_lane_in_a: assert property (!read_strobe_n_o |-> ext_data_oe_o == 2'b00)
    else $error("lane driven during read");
  strobe_excl_a: assert property (!read_strobe_n_o |->
    upper_write_strobe_n_o && lower_write_strobe_n_o) else $error("read and write strobes");
  up_lane_a: assert property (!upper_write_strobe_n_o |-> ext_data_oe_o[1])
    else $error("upper lane not driven");
  lo_lane_a: assert property (!lower_write_strobe_n_o |-> ext_data_oe_o[0])
    else $error("lower lane not driven");
  rsp_pulse_a: assert property (rsp_valid_o |=> !rsp_valid_o)
    else $error("response too long");
  cov_int_c: cover property (req_valid_i && req_ready_o && req_internal_i);
  cov_rd_c: cover property ($fell(read_strobe_n_o));
  cov_wr_c: cover property (!lower_write_strobe_n_o);
endmodule : ext_bus_if_sva
bind ext_bus_if ext_bus_if_sva u_sva (.*);
`default_nettype wire

// [test/ext_mem_model.sv]
// external memory model: read data follows the address, writes are logged
// assumes select, strobes and address come straight from the bus block
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model (
  input  wire logic        core_clk_i, // bus clock
  input  wire logic [23:0] addr_i,     // external address
  input  wire logic [7:0]  sel_n_i,    // area selects, active low
  input  wire logic        hwr_n_i,    // upper write strobe
  input  wire logic        lwr_n_i,    // lower write strobe
  input  wire logic [15:0] data_i,     // data from the block
  output logic      [15:0] data_o,     // data to the block
  output logic      [15:0] last_o,     // last written lanes
  output logic      [7:0]  up_cnt_o,   // upper write cycles
  output logic      [7:0]  lo_cnt_o    // lower write cycles
);
  logic h_q = 1'b1;    // strobe history
  logic l_q = 1'b1;    // strobe history
  logic tog_q = 1'b0;  // idle pattern toggle
  // counts and log start at zero
  initial {last_o, up_cnt_o, lo_cnt_o} = 32'h00000000;
  // drive while selected, else a toggling pattern, never stale data
  always_comb begin
    if (sel_n_i != 8'hff) data_o = {addr_i[7:0] ^ 8'h5a, addr_i[7:0] ^ 8'ha5};
    else data_o = {16{tog_q}} ^ 16'h3c3c;
  end
  // count write cycles at strobe fall, keep lane data while strobe low
  always @(posedge core_clk_i) begin
    tog_q <= ~tog_q;
    h_q <= hwr_n_i;
    l_q <= lwr_n_i;
    if (!hwr_n_i) last_o[15:8] <= data_i[15:8];
    if (!lwr_n_i) last_o[7:0] <= data_i[7:0];
    if (!hwr_n_i && h_q) up_cnt_o <= up_cnt_o + 8'h01;
    if (!lwr_n_i && l_q) lo_cnt_o <= lo_cnt_o + 8'h01;
  end
endmodule : ext_mem_model
`default_nettype wire

// [test/tb_top.sv]
// self-checking bench for the external bus block with a memory model
// assumes expanded mode strap high and on-chip rom strap low until the rom test
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ext_bus_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, perr;
  logic [25:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rwd = '0, rrd;
  logic rv = 0, rw = 0, ri = 0, rom = 0, rdy, rspv, rds, hws, lws, b16;
  logic [23:0] ra = '0, xa;
  size_t rs = SZ_BYTE;
  logic [15:0] xdi, xdo, last;
  logic [1:0] xoe;
  logic [7:0] sel_n, sel_oe, upc, loc;
  int error_cnt = 0, num_checks = 0;
  always #4 clk = ~clk;
  ext_bus_if dut (.core_clk_i(clk), .arst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(perr), .expanded_mode_i(1'b1), .rom_enabled_i(rom),
    .req_valid_i(rv), .req_ready_o(rdy), .req_addr_i(ra), .req_write_i(rw), .req_size_i(rs),
    .req_wdata_i(rwd), .req_internal_i(ri), .rsp_valid_o(rspv), .rsp_rdata_o(rrd),
    .ext_addr_o(xa), .ext_data_i(xdi), .ext_data_o(xdo), .ext_data_oe_o(xoe),
    .read_strobe_n_o(rds), .upper_write_strobe_n_o(hws), .lower_write_strobe_n_o(lws),
    .area_select_n_o(sel_n), .area_select_oe_o(sel_oe), .bus16_mode_o(b16));
  ext_mem_model mem (.core_clk_i(clk), .addr_i(xa), .sel_n_i(sel_n), .hwr_n_i(hws),
    .lwr_n_i(lws), .data_i(xdo), .data_o(xdi), .last_o(last), .up_cnt_o(upc), .lo_cnt_o(loc));
  task automatic wrap_up();
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [23:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd, output logic err);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, idx, 2'b00, 24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata[7:0];
    err = perr;
    {psel, penable} <= 2'b00;
    @(negedge clk);
    if (n >= 20) begin error_cnt++; wrap_up(); end
  endtask : apb
  // one internal-master request; returns data and edges from take to response
  task automatic req(input logic [23:0] a, input logic w, input size_t sz,
                     input logic [31:0] wd, input logic in, output logic [31:0] rd,
                     output int cyc);
    int n;
    @(posedge clk);
    {rv, ra, rw, rs, rwd, ri} <= {1'b1, a, w, sz, wd, in};
    n = 0;
    do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 50);
    rv <= 1'b0;
    cyc = 0;
    do begin @(posedge clk); cyc++; end while (rspv !== 1'b1 && cyc < 200);
    rd = rrd;
    if (n >= 50 || cyc >= 200) begin error_cnt++; wrap_up(); end
  endtask : req
  function automatic logic [15:0] pat(input logic [23:0] a);
    return {a[7:0] ^ 8'h5a, a[7:0] ^ 8'ha5};
  endfunction : pat
  logic [7:0] d;
  logic e;
  logic [31:0] r;
  int c;
  // reset values, read-only bits, unmapped place, select enables
  task automatic t_regs();
    chk("oe_rst", 8'h01, sel_oe);
    chk("bus16_rst", 1'b0, b16);
    apb(0, IDX_ADR_CTRL, 0, d, e); chk("adr_rst", 8'hff, d);
    apb(0, IDX_SEL_EN, 0, d, e); chk("selen_rst", 8'h0f, d);
    apb(0, 24'hfee017, 0, d, e); chk("unmapped", 1'b1, e);
    apb(1, IDX_ADR_CTRL, 8'h00, d, e); apb(0, IDX_ADR_CTRL, 0, d, e);
    chk("adr_mode2", 8'hfe, d);
    apb(1, IDX_SEL_EN, 8'hf0, d, e); apb(1, IDX_SEL_DIR, 8'h0f, d, e);
    chk("oe_all", 8'hff, sel_oe);
  endtask : t_regs
  // 16-bit area 1: two-state, then three-state with 0 to 3 waits
  task automatic t_timing();
    apb(1, IDX_WIDTH, 8'hfd, d, e); chk("bus16", 1'b1, b16);
    for (int s = 0; s < 5; s++) begin
      apb(1, IDX_STATES, (s == 0) ? 8'hfd : 8'hff, d, e);
      apb(1, IDX_WAIT_LO, 8'hf3 | 8'((s + 3) % 4) << 2, d, e);
      req(24'h200010, 0, SZ_WORD, 0, 0, r, c);
      chk("cycles", (s == 0) ? 3 : s + 3, c);
      chk("word_rd", pat(24'h10), r);
    end
    req(24'h200010, 0, SZ_LONG, 0, 0, r, c);
    chk("long16_cyc", 13, c);
    chk("long16_rd", {pat(24'h10), pat(24'h12)}, r);
  endtask : t_timing
  // 8-bit area 2 at reset settings: four upper-lane beats; word write is two
  task automatic t_area8();
    logic [7:0] u0, l0;
    req(24'h400020, 0, SZ_LONG, 0, 0, r, c);
    chk("long8_cyc", 25, c);
    chk("long8_rd", {8'(pat(24'h20) >> 8), 8'(pat(24'h21) >> 8), 8'(pat(24'h22) >> 8),
                     8'(pat(24'h23) >> 8)}, r);
    {u0, l0} = {upc, loc};
    req(24'h400060, 1, SZ_WORD, 32'habcd, 0, r, c);
    chk("w8_cnt", {u0 + 8'h02, l0, 8'hcd}, {upc, loc, last[15:8]});
  endtask : t_area8
  // 16-bit area byte lanes and strobes, even and odd
  task automatic t_lanes();
    logic [7:0] u0, l0;
    u0 = upc;
    l0 = loc;
    req(24'h200030, 1, SZ_BYTE, 32'h3c, 0, r, c);
    req(24'h200031, 1, SZ_BYTE, 32'hc3, 0, r, c);
    chk("wr_lanes", 16'h3cc3, last);
    chk("wr_cnt", {u0 + 8'h01, l0 + 8'h01}, {upc, loc});
    req(24'h200032, 1, SZ_WORD, 32'h1234, 0, r, c);
    chk("wr_word", {16'h1234, u0 + 8'h02, l0 + 8'h02}, {last, upc, loc});
    req(24'h200041, 0, SZ_BYTE, 0, 0, r, c); chk("rd_odd", 8'(pat(24'h41)), r);
    req(24'h200040, 0, SZ_BYTE, 0, 0, r, c); chk("rd_even", pat(24'h40) >> 8, r);
  endtask : t_lanes
  // internal accesses: fixed timing; address follows only in mode 1
  task automatic t_internal();
    req(24'h200050, 0, SZ_BYTE, 0, 0, r, c);
    req(24'hfff000, 0, SZ_WORD, 0, 1, r, c);
    chk("int_cyc", 3, c);
    chk("mode2_hold", 24'h200050, xa);
    apb(1, IDX_ADR_CTRL, 8'h01, d, e);
    req(24'hfff002, 0, SZ_WORD, 0, 1, r, c);
    chk("mode1_upd", 24'hfff002, xa);
  endtask : t_internal
  // rom strap high, fresh reset: selects 0 to 3 stay inputs
  task automatic t_rom();
    {rom, rst_n} <= 2'b10;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("oe_rom", 8'h00, sel_oe);
  endtask : t_rom
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_timing();
    t_area8();
    t_lanes();
    t_internal();
    t_rom();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
